// *** sidsm_id_mem.sv ***
`timescale 1ns/10ps
module sidsm_id_mem (
  input wire logic i_clock,
  input wire logic i_we,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  output logic [7:0] o_rdata
);
  logic [7:0] mem [0:255];

  // Read data registered, so the bus logic sees it one edge after the address flop
  always_ff @(posedge i_clock) begin
    if (i_we) begin
      mem[i_addr] <= i_wdata;
    end
    o_rdata <= mem[i_addr];
  end
endmodule

// *** sidsm_pkg.sv ***
package sidsm_pkg;

  localparam int CLK_PERIOD_NS = 8;
  localparam int GA_SETTLE_NS = 1000;
  localparam int GA_SETTLE_CYCLES = (GA_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam logic [7:0] ID_REC_ADDR = 8'hA4;
  localparam logic [7:0] CHASSIS_FN_LO = 8'h58;
  localparam logic [7:0] CHASSIS_FN_HI = 8'h5C;
  localparam logic [7:0] SYS_RSV_LO = 8'hC6;
  localparam logic [7:0] SYS_RSV_HI = 8'hC8;
  localparam logic [7:0] ARP_DEFAULT_ADDR = 8'hC2;
  localparam logic [7:0] ARP_CMD_ASSIGN = 8'h04;
  localparam logic [7:0] CHASSIS_FN_ADDR = 8'h58;

  localparam logic [7:0] DESC_BASE = 8'h10;
  localparam int DESC_SHIFT = 2;
  localparam logic [4:0] SYSTEM_SLOT = 5'h01;
  localparam logic [7:0] GA_CNT_ONE = 8'h01;
  localparam logic [7:0] GA_CNT_DONE = 8'(GA_SETTLE_CYCLES);
  localparam logic [1:0] DESC_WAIT_DONE = 2'h2;
  localparam logic [2:0] LAST_BIT = 3'h7;

  localparam logic [2:0] SLOT_TYPE_NA = 3'h0;
  localparam logic [2:0] SLOT_TYPE_PERIPH = 3'h1;
  localparam logic [2:0] SLOT_TYPE_LEGACY = 3'h2;
  localparam logic [2:0] SLOT_TYPE_HYBRID = 3'h3;
  localparam logic [2:0] SLOT_TYPE_TIMING = 3'h7;

  typedef enum logic [1:0] {
    ROLE_PERIPH = 2'h0,
    ROLE_SYSTEM = 2'h1,
    ROLE_LEGACY = 2'h2,
    ROLE_HYBRID_LEGACY = 2'h3
  } sidsm_role_e;

  typedef enum logic [2:0] {
    TGT_NONE = 3'h0,
    TGT_REC = 3'h1,
    TGT_FN = 3'h2,
    TGT_ARP = 3'h3,
    TGT_DYN = 3'h4
  } sidsm_tgt_e;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_RX = 6'h02,
    ST_ACK_SETUP = 6'h04,
    ST_ACK_HOLD = 6'h08,
    ST_TX = 6'h10,
    ST_TX_ACK = 6'h20
  } sidsm_state_e;

endpackage

// *** sidsm_slot_id.sv ***
`timescale 1ns/10ps
// How it works
// - Non-system modules let host software read the five geographic address pin levels.
// - The system module always reports slot one instead of its pins.
// - Legacy and hybrid-legacy modules need not offer the slot value; flagged invalid.
// - The module reports its own slot number on a dedicated output.
// - The identification record lives in a byte memory reached over the management bus.
// - Slot-type bits 2:0 decode to n/a, peripheral, legacy, hybrid or timing slot.
// - Address A4h belongs only to the identification record; nothing else may claim it.
// - Chassis-function devices answer only inside 58h to 5Ch.
// - Addresses are eight-bit; bit zero picks write (even) or read (odd).
// - Peripheral devices take a dynamic address through address resolution.
module sidsm_slot_id (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_role,
  input wire logic [4:0] i_geo_slot_addr_bits,
  input wire logic i_smb_clk,
  input wire logic i_smb_dat,
  output logic o_smb_dat_out,
  output logic o_smb_dat_oe,
  output logic [4:0] o_slot_number,
  output logic o_slot_valid,
  output logic [2:0] o_slot_type,
  output logic o_slot_type_known,
  output logic [7:0] o_dyn_addr,
  output logic o_dyn_addr_valid
);

  typedef struct packed {
    sidsm_pkg::sidsm_role_e role;
    logic [4:0] ga_s1;
    logic [4:0] ga_s2;
    logic [4:0] ga_cand;
    logic [7:0] ga_cnt;
    logic [4:0] geo;
    logic geo_ok;
    logic scl_d;
    logic sda_d;
    sidsm_pkg::sidsm_state_e st;
    logic [2:0] bitcnt;
    logic [7:0] shreg;
    sidsm_pkg::sidsm_tgt_e tgt;
    logic rd;
    logic addr_phase;
    logic ptr_set;
    logic [7:0] ptr;
    logic [7:0] arp_cmd;
    logic arp_cmd_ok;
    logic [7:0] dyn_addr;
    logic dyn_ok;
    logic sda_oe;
    logic [2:0] slot_type;
    logic type_ok;
    logic [1:0] desc_wait;
    logic mem_we;
    logic [7:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [4:0] slot_num;
    logic slot_valid;
  } sidsm_state_s;

  sidsm_state_s s;
  sidsm_state_s next_s;
  logic [7:0] mem_rdata;

  // Not cleared by reset: the slot type reads unknown until the record has been written
  sidsm_id_mem u_id_mem (
    .i_clock(i_clock),
    .i_we(s.mem_we),
    .i_addr(s.mem_addr),
    .i_wdata(s.mem_wdata),
    .o_rdata(mem_rdata)
  );

  // True for any eight-bit address held back for the record, chassis functions or system use
  function automatic logic sidsm_addr_reserved(input logic [7:0] a);
    logic [7:0] ev;
    ev = {a[7:1], 1'b0};
    sidsm_addr_reserved = (ev == sidsm_pkg::ID_REC_ADDR) ||
                          (ev >= {sidsm_pkg::CHASSIS_FN_LO[7:1], 1'b0} && ev <= sidsm_pkg::CHASSIS_FN_HI) ||
                          (ev >= {sidsm_pkg::SYS_RSV_LO[7:1], 1'b0} && ev <= sidsm_pkg::SYS_RSV_HI);
  endfunction

  // Compares only the seven address bits; bit zero is the direction
  function automatic logic sidsm_addr_hit(input logic [7:0] rx, input logic [7:0] own);
    sidsm_addr_hit = (rx[7:1] == own[7:1]);
  endfunction

  function automatic logic sidsm_type_known(input logic [2:0] t);
    sidsm_type_known = (t == sidsm_pkg::SLOT_TYPE_NA) || (t == sidsm_pkg::SLOT_TYPE_PERIPH) ||
                       (t == sidsm_pkg::SLOT_TYPE_LEGACY) || (t == sidsm_pkg::SLOT_TYPE_HYBRID) ||
                       (t == sidsm_pkg::SLOT_TYPE_TIMING);
  endfunction

  always_comb begin
    logic scl_rise;
    logic scl_fall;
    logic start_c;
    logic stop_c;
    logic [7:0] rx_byte;
    logic [7:0] tx_byte;
    logic is_periph;
    logic fn_legal;
    scl_rise = i_smb_clk && !s.scl_d;
    scl_fall = !i_smb_clk && s.scl_d;
    start_c = i_smb_clk && s.scl_d && s.sda_d && !i_smb_dat;
    stop_c = i_smb_clk && s.scl_d && !s.sda_d && i_smb_dat;
    rx_byte = {s.shreg[6:0], i_smb_dat};
    is_periph = (s.role == sidsm_pkg::ROLE_PERIPH);
    // Fixed guard: a chassis function address outside its window is never decoded
    fn_legal = (sidsm_pkg::CHASSIS_FN_ADDR >= sidsm_pkg::CHASSIS_FN_LO) &&
               (sidsm_pkg::CHASSIS_FN_ADDR <= sidsm_pkg::CHASSIS_FN_HI);
    tx_byte = (s.tgt == sidsm_pkg::TGT_REC) ? mem_rdata : {3'h0, s.slot_num};

    next_s = s;
    next_s.mem_we = 1'b0;
    next_s.scl_d = i_smb_clk;
    next_s.sda_d = i_smb_dat;

    // Double flop then a settle filter, so a slot value seen mid-insertion never reaches software
    next_s.ga_s1 = i_geo_slot_addr_bits;
    next_s.ga_s2 = s.ga_s1;
    if (s.ga_s2 != s.ga_cand) begin
      next_s.ga_cand = s.ga_s2;
      next_s.ga_cnt = '0;
    end else if (s.ga_cnt != sidsm_pkg::GA_CNT_DONE) begin
      next_s.ga_cnt = s.ga_cnt + sidsm_pkg::GA_CNT_ONE;
    end else begin
      next_s.geo = s.ga_cand;
      next_s.geo_ok = 1'b1;
    end

    case (s.role)
      sidsm_pkg::ROLE_SYSTEM: begin
        next_s.slot_num = sidsm_pkg::SYSTEM_SLOT;
        next_s.slot_valid = 1'b1;
      end
      sidsm_pkg::ROLE_LEGACY, sidsm_pkg::ROLE_HYBRID_LEGACY: begin
        next_s.slot_num = s.geo;
        next_s.slot_valid = 1'b0;
      end
      default: begin
        next_s.slot_num = s.geo;
        next_s.slot_valid = s.geo_ok;
      end
    endcase

    // While the bus is quiet the memory looks up this slot's descriptor
    if (s.st == sidsm_pkg::ST_IDLE) begin
      next_s.mem_addr = 8'(sidsm_pkg::DESC_BASE + ({3'h0, s.slot_num} << sidsm_pkg::DESC_SHIFT));
      if (next_s.mem_addr != s.mem_addr) begin
        next_s.desc_wait = '0;
      end else if (s.desc_wait != sidsm_pkg::DESC_WAIT_DONE) begin
        next_s.desc_wait = s.desc_wait + 2'h1;
      end else if (s.slot_valid) begin
        next_s.slot_type = mem_rdata[2:0];
        next_s.type_ok = sidsm_type_known(mem_rdata[2:0]);
      end
    end else begin
      next_s.mem_addr = s.ptr;
      next_s.desc_wait = '0;
    end

    if (start_c) begin
      next_s.st = sidsm_pkg::ST_RX;
      next_s.bitcnt = '0;
      next_s.addr_phase = 1'b1;
      next_s.sda_oe = 1'b0;
      next_s.ptr_set = 1'b0;
    end else if (stop_c) begin
      next_s.st = sidsm_pkg::ST_IDLE;
      next_s.sda_oe = 1'b0;
    end else begin
      case (s.st)
        sidsm_pkg::ST_IDLE: begin
          next_s.sda_oe = 1'b0;
        end
        sidsm_pkg::ST_RX: begin
          if (scl_rise) begin
            next_s.shreg = rx_byte;
            next_s.bitcnt = s.bitcnt + 3'h1;
            if (s.bitcnt == sidsm_pkg::LAST_BIT) begin
              next_s.st = sidsm_pkg::ST_ACK_SETUP;
              if (s.addr_phase) begin
                next_s.addr_phase = 1'b0;
                next_s.rd = rx_byte[0];
                next_s.arp_cmd_ok = 1'b0;
                if (sidsm_addr_hit(rx_byte, sidsm_pkg::ID_REC_ADDR)) begin
                  next_s.tgt = sidsm_pkg::TGT_REC;
                end else if (fn_legal && sidsm_addr_hit(rx_byte, sidsm_pkg::CHASSIS_FN_ADDR)) begin
                  next_s.tgt = sidsm_pkg::TGT_FN;
                end else if (is_periph && !rx_byte[0] && sidsm_addr_hit(rx_byte, sidsm_pkg::ARP_DEFAULT_ADDR)) begin
                  next_s.tgt = sidsm_pkg::TGT_ARP;
                end else if (is_periph && s.dyn_ok && sidsm_addr_hit(rx_byte, s.dyn_addr)) begin
                  next_s.tgt = sidsm_pkg::TGT_DYN;
                end else begin
                  next_s.tgt = sidsm_pkg::TGT_NONE;
                  next_s.st = sidsm_pkg::ST_IDLE;
                end
              end else if (s.tgt == sidsm_pkg::TGT_REC) begin
                if (!s.ptr_set) begin
                  next_s.ptr = rx_byte;
                  next_s.ptr_set = 1'b1;
                end else begin
                  next_s.mem_we = 1'b1;
                  next_s.mem_addr = s.ptr;
                  next_s.mem_wdata = rx_byte;
                  next_s.ptr = s.ptr + 8'h01;
                end
              end else if (s.tgt == sidsm_pkg::TGT_ARP) begin
                if (!s.arp_cmd_ok) begin
                  next_s.arp_cmd = rx_byte;
                  next_s.arp_cmd_ok = 1'b1;
                end else if (s.arp_cmd == sidsm_pkg::ARP_CMD_ASSIGN) begin
                  // Reserved addresses are refused so no peripheral can shadow the record or chassis
                  if (!sidsm_addr_reserved(rx_byte)) begin
                    next_s.dyn_addr = {rx_byte[7:1], 1'b0};
                    next_s.dyn_ok = 1'b1;
                  end
                end
              end
            end
          end
        end
        // Ack waits for the clock fall so the data line never moves while the clock is high
        sidsm_pkg::ST_ACK_SETUP: begin
          if (scl_fall) begin
            next_s.sda_oe = 1'b1;
            next_s.st = sidsm_pkg::ST_ACK_HOLD;
          end
        end
        sidsm_pkg::ST_ACK_HOLD: begin
          if (scl_fall) begin
            next_s.bitcnt = '0;
            if (s.rd) begin
              next_s.shreg = tx_byte;
              next_s.sda_oe = !tx_byte[7];
              next_s.st = sidsm_pkg::ST_TX;
              if (s.tgt == sidsm_pkg::TGT_REC) begin
                next_s.ptr = s.ptr + 8'h01;
              end
            end else begin
              next_s.sda_oe = 1'b0;
              next_s.st = sidsm_pkg::ST_RX;
            end
          end
        end
        sidsm_pkg::ST_TX: begin
          if (scl_fall) begin
            next_s.bitcnt = s.bitcnt + 3'h1;
            next_s.shreg = {s.shreg[6:0], 1'b0};
            if (s.bitcnt == sidsm_pkg::LAST_BIT) begin
              next_s.sda_oe = 1'b0;
              next_s.st = sidsm_pkg::ST_TX_ACK;
            end else begin
              next_s.sda_oe = !s.shreg[6];
            end
          end
        end
        sidsm_pkg::ST_TX_ACK: begin
          if (scl_rise) begin
            next_s.st = i_smb_dat ? sidsm_pkg::ST_IDLE : sidsm_pkg::ST_ACK_HOLD;
          end
        end
        default: begin
          next_s.st = sidsm_pkg::ST_IDLE;
          next_s.sda_oe = 1'b0;
        end
      endcase
    end

    if (i_sys_rst) begin
      next_s = '0;
      next_s.st = sidsm_pkg::ST_IDLE;
      next_s.tgt = sidsm_pkg::TGT_NONE;
      next_s.scl_d = 1'b1;
      next_s.sda_d = 1'b1;
      // The strap is caught each reset cycle and holds once reset is released
      next_s.role = sidsm_pkg::sidsm_role_e'(i_role);
    end
  end

  always_ff @(posedge i_clock) begin
    s <= next_s;
  end

  // Outputs other than o_smb_dat_out (held at zero) copy the next state, so they change on the same edge as the state itself
  always_ff @(posedge i_clock) begin
    o_smb_dat_out <= 1'b0;
    o_smb_dat_oe <= i_sys_rst ? 1'b0 : next_s.sda_oe;
    o_slot_number <= i_sys_rst ? 5'h00 : next_s.slot_num;
    o_slot_valid <= i_sys_rst ? 1'b0 : next_s.slot_valid;
    o_slot_type <= i_sys_rst ? 3'h0 : next_s.slot_type;
    o_slot_type_known <= i_sys_rst ? 1'b0 : next_s.type_ok;
    o_dyn_addr <= i_sys_rst ? 8'h00 : next_s.dyn_addr;
    o_dyn_addr_valid <= i_sys_rst ? 1'b0 : next_s.dyn_ok;
  end

endmodule

// *** sidsm_slot_id_chk.sv ***
`timescale 1ns/10ps
module sidsm_slot_id_chk (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic [1:0] i_role,
  input wire logic [4:0] i_geo_slot_addr_bits,
  input wire logic i_smb_clk,
  input wire logic o_smb_dat_oe,
  input wire logic [4:0] o_slot_number,
  input wire logic o_slot_valid,
  input wire logic [2:0] o_slot_type,
  input wire logic o_slot_type_known,
  input wire logic [7:0] o_dyn_addr,
  input wire logic o_dyn_addr_valid
);
  logic [7:0] calm;
  // Cycles since the slot pins last moved; saturates so it never wraps
  always_ff @(posedge i_clock) begin
    if (i_sys_rst || $changed(i_geo_slot_addr_bits)) begin
      calm <= 8'h00;
    end else if (calm != 8'hFF) begin
      calm <= calm + 8'h01;
    end
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence s_hold2;
    $stable(o_smb_dat_oe)[*2];
  endsequence
  chk_pins_reported: assert property (
    calm == 8'hC8 && i_role != 2'h1 |-> o_slot_number == i_geo_slot_addr_bits)
    else $error("slot number does not follow pins");
  chk_sys_slot: assert property (
    calm == 8'hC8 && i_role == 2'h1 |-> o_slot_valid && o_slot_number == 5'h01)
    else $error("system slot not one");
  chk_legacy_inv: assert property (i_role[1] |-> !o_slot_valid)
    else $error("legacy role shows valid slot");
  chk_type_known: assert property (
    o_slot_type != 3'h0 |-> o_slot_type_known == (o_slot_type inside {3'h1, 3'h2, 3'h3, 3'h7}))
    else $error("slot type flag wrong");
  chk_slot_filter: assert property ($changed(i_geo_slot_addr_bits) |=> $stable(o_slot_number)[*8])
    else $error("slot number not filtered");
  chk_oe_low_clk: assert property ($changed(o_smb_dat_oe) |-> !i_smb_clk)
    else $error("data moved while clock high");
  chk_oe_hold: assert property ($rose(o_smb_dat_oe) |=> s_hold2)
    else $error("data pull too short");
  chk_dyn_even: assert property (o_dyn_addr_valid |-> !o_dyn_addr[0])
    else $error("dynamic address odd");
  chk_dyn_free: assert property (
    o_dyn_addr_valid |-> !(o_dyn_addr inside {8'hA4, [8'h58:8'h5D], [8'hC6:8'hC9]}))
    else $error("dynamic address reserved");
endmodule

// *** sidsm_smb_host.sv ***
`timescale 1ns/10ps
module sidsm_smb_host #(
  parameter int HALF = 8
) (
  input wire logic i_clock,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_low
);
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0; // Host masters only and claims no address, reserved ones included
  end
  task automatic tick();
    repeat (HALF) @(posedge i_clock);
    #1;
  endtask
  // Data only moves a full phase after the clock fall, past the target's hold
  task automatic bit_io(input logic d, output logic s);
    tick();
    o_sda_low = !d;
    tick();
    o_scl = 1'b1;
    tick();
    s = i_sda;
    o_scl = 1'b0;
  endtask
  // Also a repeated start: data rises while clock low
  task automatic start();
    tick();
    o_sda_low = 1'b0;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_low = 1'b1;
    tick();
    o_scl = 1'b0;
  endtask
  task automatic stop();
    tick();
    o_sda_low = 1'b1;
    tick();
    o_scl = 1'b1;
    tick();
    o_sda_low = 1'b0;
    tick();
  endtask
  task automatic wbyte(input logic [7:0] b, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(b[i], s);
    end
    bit_io(1'b1, s);
    ack = !s;
  endtask
  task automatic rbyte(output logic [7:0] d, input logic more);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(!more, s);
  endtask
endmodule

// *** slot_id_smbus_addressing_test.sv ***
`timescale 1ns/10ps
module slot_id_smbus_addressing_test;
  logic i_clock = 1'b0;
  logic rst = 1'b1;
  logic [1:0] role = 2'h0;
  logic [4:0] pins = 5'h03;
  logic scl;
  logic host_low;
  logic oe;
  logic dout;
  logic [4:0] num;
  logic valid;
  logic [2:0] typ;
  logic known;
  logic [7:0] dyn;
  logic dyn_ok;
  logic sda;
  int mismatches = 0;
  int tests_run = 0;
  int cycles = 0;
  // Open-drain data line with pull-up
  assign sda = !host_low && !(oe && !dout);
  always #4 i_clock = ~i_clock;
  sidsm_slot_id dut (.i_clock(i_clock), .i_sys_rst(rst), .i_role(role), .i_geo_slot_addr_bits(pins),
    .i_smb_clk(scl), .i_smb_dat(sda), .o_smb_dat_out(dout), .o_smb_dat_oe(oe), .o_slot_number(num),
    .o_slot_valid(valid), .o_slot_type(typ), .o_slot_type_known(known), .o_dyn_addr(dyn),
    .o_dyn_addr_valid(dyn_ok));
  sidsm_smb_host host (.i_clock(i_clock), .i_sda(sda), .o_scl(scl), .o_sda_low(host_low));
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      tally_and_finish();
    end
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
    #1;
  endtask
  // Long enough for the pin filter to settle after release
  task automatic do_reset(input logic [1:0] r);
    role = r;
    rst = 1'b1;
    cyc(8);
    rst = 1'b0;
    cyc(210);
  endtask
  task automatic wb(input logic [7:0] b, input logic exp);
    logic a;
    host.wbyte(b, a);
    check(8'(a), 8'(exp));
  endtask
  // Write frame of n bytes; the address byte expects exp, the rest an ack
  task automatic frame(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d, input int n,
                       input logic exp);
    host.start();
    wb(a, exp);
    if (n > 1) begin
      wb(p, 1'b1);
    end
    if (n > 2) begin
      wb(d, 1'b1);
    end
    host.stop();
  endtask
  // One-byte read frame; the byte must equal exp
  task automatic rd1(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    host.start();
    wb(a, 1'b1);
    host.rbyte(d, 1'b0);
    host.stop();
    check(d, exp);
  endtask
  task automatic t_slot();
    check(8'(num), 8'h03);
    check(8'(valid), 8'h01);
    check(8'(dout), 8'h00);
    pins = 5'h1A;
    cyc(60);
    check(8'(num), 8'h03);
    cyc(150);
    check(8'(num), 8'h1A);
    pins = 5'h03;
    cyc(210);
  endtask
  task automatic t_types();
    logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7, 3'h5};
    logic [7:0] p;
    logic [7:0] d;
    p = 8'(sidsm_pkg::DESC_BASE + (8'h03 << sidsm_pkg::DESC_SHIFT));
    foreach (codes[i]) begin
      frame(8'hA4, p, {5'h00, codes[i]}, 3, 1'b1);
      cyc(20);
      check(8'(typ), 8'(codes[i]));
      check(8'(known), 8'(codes[i] inside {3'h0, 3'h1, 3'h2, 3'h3, 3'h7}));
    end
    frame(8'hA4, 8'h1D, 8'h6C, 3, 1'b1);
    host.start();
    wb(8'hA4, 1'b1);
    wb(p, 1'b1);
    host.start();
    wb(8'hA5, 1'b1);
    host.rbyte(d, 1'b1);
    check(d, 8'h05);
    host.rbyte(d, 1'b0);
    host.stop();
    check(d, 8'h6C);
  endtask
  task automatic t_addr();
    logic [7:0] adr [5] = '{8'h58, 8'h5E, 8'hC6, 8'hA6, 8'h50};
    foreach (adr[i]) begin
      frame(adr[i], 8'h00, 8'h00, 1, adr[i] == 8'h58);
    end
    rd1(8'h59, 8'h03);
  endtask
  task automatic t_arp();
    logic [7:0] na [3] = '{8'hA4, 8'h5A, 8'h30};
    foreach (na[i]) begin
      frame(8'hC2, 8'h04, na[i], 3, 1'b1);
      cyc(4);
      check(8'(dyn_ok), 8'(na[i] == 8'h30));
    end
    frame(8'hC2, 8'h01, 8'h40, 3, 1'b1);
    cyc(4);
    check(dyn, 8'h30);
    frame(8'h30, 8'h00, 8'h00, 1, 1'b1);
    rd1(8'h31, 8'h03);
  endtask
  task automatic t_roles();
    do_reset(sidsm_pkg::ROLE_SYSTEM);
    check(8'(num), 8'h01);
    frame(8'hC2, 8'h00, 8'h00, 1, 1'b0);
    do_reset(sidsm_pkg::ROLE_LEGACY);
    check(8'(valid), 8'h00);
    do_reset(sidsm_pkg::ROLE_HYBRID_LEGACY);
    check(8'(valid), 8'h00);
  endtask
  initial begin
    do_reset(sidsm_pkg::ROLE_PERIPH);
    t_slot();
    t_types();
    t_addr();
    t_arp();
    t_roles();
    tally_and_finish();
  end
endmodule
bind sidsm_slot_id sidsm_slot_id_chk chk (.i_clock(i_clock), .i_sys_rst(i_sys_rst), .i_role(i_role),
  .i_geo_slot_addr_bits(i_geo_slot_addr_bits), .i_smb_clk(i_smb_clk), .o_smb_dat_oe(o_smb_dat_oe),
  .o_slot_number(o_slot_number), .o_slot_valid(o_slot_valid), .o_slot_type(o_slot_type),
  .o_slot_type_known(o_slot_type_known), .o_dyn_addr(o_dyn_addr), .o_dyn_addr_valid(o_dyn_addr_valid));
